// [hdl/ivp_arbiter.sv]
// Interrupt vector and priority arbiter for a signal processor core.
// Assumes all request inputs are levels held until serviced, synchronous to mclk.
//
// What this block does
// - Level 3 is nonmaskable; peripheral and external sources take maskable levels 0 to 2.
// - Host command vectors to slot 0x72 joined to the base, nonmaskable by default, else maskable.
// - Nonmaskable order: reset, stack, illegal, debug, trap, NMI, host command.
// - Core slots at 0x00 to 0x0A; 0x0C and 0x0E reserved.
// - Maskable ties: external A-D, DMA 0-5, host command, then host port sources.
// - Host port order: termination, abort, parity, complete, master/slave receive, transmit, address.
// - Sync port order: rx exception, rx, rx last, tx exception, tx last, tx; port 0 first.
// - Then async: rx exception, rx, tx, idle, timer; then timers, overflow before compare.
// - Sync port 0 slots 0x30 to 0x3A; 0x3C and 0x3E reserved.
// - Sync port 1 slots 0x40 to 0x4A; 0x4C and 0x4E reserved.
// - Async slots 0x50 to 0x58; 0x5A to 0x5E unassigned.
// - Host port slots 0x60 to 0x70 in two-word steps.
`timescale 1ns/100ps

module ivp_arbiter
    import ivp_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Core exception requests and the core's current mask level.
    input wire logic core_req_reset,
    input wire logic core_req_stack,
    input wire logic core_req_illegal,
    input wire logic core_req_debug,
    input wire logic core_req_trap,
    input wire logic core_req_nmi,
    input wire logic [ivp_pkg::LVL_W-1:0] core_mask,
    input wire logic [ivp_pkg::ADDR_W-1:0] vector_base,
    // External request pins, each with its own level.
    input wire logic ext_request_a,
    input wire logic ext_request_b,
    input wire logic ext_request_c,
    input wire logic ext_request_d,
    input wire logic [ivp_pkg::N_EXT-1:0][ivp_pkg::LVL_W-1:0] ext_level,
    // DMA channels, each with its own level.
    input wire logic [ivp_pkg::N_DMA-1:0] dma_req,
    input wire logic [ivp_pkg::N_DMA-1:0][ivp_pkg::LVL_W-1:0] dma_level,
    // Host port and host command.
    input wire logic host_cmd_req,
    input wire logic host_cmd_maskable,
    input wire logic [ivp_pkg::N_HOST-1:0] host_req,
    input wire logic [ivp_pkg::LVL_W-1:0] host_level,
    // Serial ports.
    input wire logic [ivp_pkg::N_SSP-1:0] sync_serial_port0_req,
    input wire logic [ivp_pkg::LVL_W-1:0] sync_serial_port0_level,
    input wire logic [ivp_pkg::N_SSP-1:0] sync_serial_port1_req,
    input wire logic [ivp_pkg::LVL_W-1:0] sync_serial_port1_level,
    input wire logic [ivp_pkg::N_ASP-1:0] async_serial_port_req,
    input wire logic [ivp_pkg::LVL_W-1:0] async_serial_port_level,
    // Timers.
    input wire logic [ivp_pkg::N_TMR-1:0] timer_req,
    input wire logic [ivp_pkg::LVL_W-1:0] timer_level,
    // Grant to the core sequencer.
    output logic irq_valid,
    output logic [ivp_pkg::LVL_W-1:0] irq_level,
    output logic [ivp_pkg::IDX_W-1:0] irq_source,
    output logic [ivp_pkg::ADDR_W-1:0] irq_address
);

    import ivp_pkg::*;

    logic [NSRC-1:0] src_req;
    logic [NSRC-1:0][LVL_W-1:0] src_lvl;
    logic [NSRC-1:0] src_elig;
    logic [NLVL-1:0][NSRC-1:0] lvl_req;
    logic [NLVL-1:0] pick_any;
    logic [NLVL-1:0][IDX_W-1:0] pick_idx;
    logic next_valid;
    logic [LVL_W-1:0] next_level;
    logic [IDX_W-1:0] next_source;
    logic [ADDR_W-1:0] next_address;

    // Lays every request out in the fixed priority order with its level.
    always_comb begin
        src_req = '0;
        src_lvl = '0;
        // Core exceptions sit at the nonmaskable level, reset first.
        src_req[IDX_RESET] = core_req_reset;
        src_req[IDX_STACK] = core_req_stack;
        src_req[IDX_ILLEGAL] = core_req_illegal;
        src_req[IDX_DEBUG] = core_req_debug;
        src_req[IDX_TRAP] = core_req_trap;
        src_req[IDX_NMI] = core_req_nmi;
        for (int i = IDX_RESET; i <= IDX_HC_NMI; i++) begin
            src_lvl[i] = LVL_NMI;
        end
        // Host command goes nonmaskable unless software chose the maskable form.
        src_req[IDX_HC_NMI] = host_cmd_req && !host_cmd_maskable;
        src_req[IDX_HC] = host_cmd_req && host_cmd_maskable;
        src_lvl[IDX_HC] = host_level;
        // External pins come first among maskable sources, then DMA.
        src_req[IDX_EXT + 0] = ext_request_a;
        src_req[IDX_EXT + 1] = ext_request_b;
        src_req[IDX_EXT + 2] = ext_request_c;
        src_req[IDX_EXT + 3] = ext_request_d;
        for (int i = 0; i < N_EXT; i++) begin
            src_lvl[IDX_EXT + i] = ext_level[i];
        end
        for (int i = 0; i < N_DMA; i++) begin
            src_req[IDX_DMA + i] = dma_req[i];
            src_lvl[IDX_DMA + i] = dma_level[i];
        end
        // Host port sources follow the host command, bit 0 first.
        for (int i = 0; i < N_HOST; i++) begin
            src_req[IDX_HOST + i] = host_req[i];
            src_lvl[IDX_HOST + i] = host_level;
        end
        // Sync port 0 ranks wholly above sync port 1.
        for (int i = 0; i < N_SSP; i++) begin
            src_req[IDX_SSP0 + i] = sync_serial_port0_req[i];
            src_lvl[IDX_SSP0 + i] = sync_serial_port0_level;
            src_req[IDX_SSP1 + i] = sync_serial_port1_req[i];
            src_lvl[IDX_SSP1 + i] = sync_serial_port1_level;
        end
        // Async port, then the timers at the very bottom.
        for (int i = 0; i < N_ASP; i++) begin
            src_req[IDX_ASP + i] = async_serial_port_req[i];
            src_lvl[IDX_ASP + i] = async_serial_port_level;
        end
        for (int i = 0; i < N_TMR; i++) begin
            src_req[IDX_TMR + i] = timer_req[i];
            src_lvl[IDX_TMR + i] = timer_level;
        end
    end

    // A maskable source counts only if enabled and not below the core mask.
    always_comb begin
        src_elig = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (i <= IDX_HC_NMI) begin
                src_elig[i] = src_req[i];
            end else begin
                src_elig[i] = src_req[i] && (src_lvl[i] != LVL_OFF) && (src_lvl[i] >= core_mask);
            end
        end
    end

    // Splits the eligible requests by level; one process keeps a single driver on the whole array.
    always_comb begin
        lvl_req = '0;
        for (int l = 0; l < NLVL; l++) begin
            for (int i = 0; i < NSRC; i++) begin
                lvl_req[l][i] = src_elig[i] && (src_lvl[i] == LVL_W'(l));
            end
        end
    end

    // One first-set picker per level gives the in-level tie winner.
    genvar gl;
    generate
        for (gl = 0; gl < NLVL; gl++) begin : g_lvl
            ivp_first_pick #(
                .N(NSRC),
                .W(IDX_W)
            ) u_pick (
                .req(lvl_req[gl]),
                .any(pick_any[gl]),
                .idx(pick_idx[gl])
            );
        end
    endgenerate

    // The highest level holding any request wins; the slot joins the base.
    always_comb begin
        next_valid = 1'b0;
        next_level = RST_LVL;
        next_source = RST_SRC;
        for (int l = 0; l < NLVL; l++) begin
            if (pick_any[l]) begin
                next_valid = 1'b1;
                next_level = LVL_W'(l);
                next_source = pick_idx[l];
            end
        end
        next_address = {vector_base[ADDR_W-1:SLOT_W], SLOT[next_source]};
    end

    // Registers the grant so every output comes from a flip-flop.
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_valid <= 1'b0;
            irq_level <= RST_LVL;
            irq_source <= RST_SRC;
            irq_address <= RST_ADDR;
        end else begin
            irq_valid <= next_valid;
            irq_level <= next_level;
            irq_source <= next_source;
            irq_address <= next_address;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // No core exception pending in a cycle.
    sequence s_core_quiet;
        !(core_req_reset || core_req_stack || core_req_illegal || core_req_debug || core_req_trap || core_req_nmi);
    endsequence

    // Core reset request is pending.
    sequence s_reset_req;
        core_req_reset;
    endsequence

    // No nonmaskable host command is pending.
    sequence s_hc_nmi_idle;
        !(host_cmd_req && !host_cmd_maskable);
    endsequence

    chk_nm_always_taken: assert property (s_reset_req |=> irq_valid && irq_level == 2'h3)
        else $error("Nonmaskable request was not granted at level 3.");

    chk_hc_nmi_slot: assert property (s_core_quiet ##0 (host_cmd_req && !host_cmd_maskable)
        |=> irq_valid && irq_level == 2'h3 && irq_address[7:0] == 8'h72)
        else $error("Nonmaskable host command did not vector to slot 0x72.");

    chk_reset_first: assert property (s_reset_req |=> irq_source == 6'h00 && irq_address[7:0] == 8'h00)
        else $error("Reset request did not win over other requests.");

    chk_trap_slot: assert property ((core_req_trap && !core_req_reset && !core_req_stack
        && !core_req_illegal && !core_req_debug) |=> irq_address[7:0] == 8'h08)
        else $error("Trap did not vector to slot 0x08.");

    chk_ext_a_tie: assert property ((src_elig[IDX_EXT] && pick_any[src_lvl[IDX_EXT]]
        && !(|pick_any[3:1] && src_lvl[IDX_EXT] == 2'h0) && next_level == src_lvl[IDX_EXT])
        |=> irq_source == 6'h07 && irq_address[7:0] == 8'h10)
        else $error("External request A lost a tie at its own level.");

    chk_ssp0_rx_exc: assert property ((next_valid && next_source == 6'h1B) |=> irq_address[7:0] == 8'h32)
        else $error("Sync port 0 exception receive slot is wrong.");

    chk_level_wins: assert property (s_core_quiet ##0 s_hc_nmi_idle
        ##0 (src_elig[IDX_TMR + 5] && timer_level == 2'h2) |=> irq_valid && irq_level == 2'h2)
        else $error("A lower level won over a pending level 2 request.");

    chk_timer_low: assert property ((next_valid && next_source == 6'h31)
        |-> lvl_req[next_level][NSRC-2:0] == '0)
        else $error("Timer 2 compare won a tie it should have lost.");

    chk_addr_join: assert property (irq_valid |-> irq_address[23:8] == $past(vector_base[23:8])
        && irq_address[7:0] == SLOT[irq_source])
        else $error("Grant address is not base joined with the winner's slot.");

    chk_masked_quiet: assert property ((s_core_quiet ##0 (!host_cmd_req && core_mask == 2'h3))
        |=> !irq_valid)
        else $error("A request was granted while all maskable levels were masked.");

    // A maskable grant never sits below the mask that was in force when it was chosen.
    chk_mask_obeyed: assert property ((irq_valid && irq_level != LVL_NMI)
        |-> irq_level >= $past(core_mask))
        else $error("A maskable grant was below the core mask.");

    // Core exceptions and the nonmaskable host command always carry level 3.
    chk_nm_level: assert property ((irq_valid && irq_source <= IDX_HC_NMI) |-> irq_level == LVL_NMI)
        else $error("A nonmaskable source was granted below level 3.");

    // The chosen source really is an eligible request at the chosen level.
    chk_winner_real: assert property (next_valid
        |-> src_elig[next_source] && src_lvl[next_source] == next_level)
        else $error("The chosen source was not an eligible request at its level.");

    // The maskable host command vectors to its shared slot at the host level.
    chk_hc_mask_slot: assert property ((next_valid && next_source == IDX_HC)
        |=> irq_address[7:0] == 8'h72 && irq_level == $past(host_level))
        else $error("Maskable host command did not vector to slot 0x72 at the host level.");

    // DMA channel 5 wins only when no external pin or lower-numbered channel asks at its level.
    chk_dma_order: assert property ((next_valid && next_source == IDX_DMA + N_DMA - 1)
        |-> lvl_req[next_level][IDX_EXT +: N_EXT + N_DMA - 1] == '0)
        else $error("DMA channel 5 won over a higher source at its level.");

    // The master address request ranks last among host port sources.
    chk_host_order: assert property ((next_valid && next_source == IDX_HOST + N_HOST - 1)
        |-> lvl_req[next_level][IDX_HOST +: N_HOST - 1] == '0)
        else $error("Host master address request won over another host source.");

    // Sync port 1 yields to every host and sync port 0 source at its level.
    chk_ssp_order: assert property ((next_valid && next_source == IDX_SSP1)
        |-> lvl_req[next_level][IDX_HOST +: N_HOST + N_SSP] == '0)
        else $error("Sync port 1 won over a host or sync port 0 source.");

    // The async port yields to both sync ports at its level.
    chk_async_order: assert property ((next_valid && next_source == IDX_ASP)
        |-> lvl_req[next_level][IDX_SSP0 +: 2 * N_SSP] == '0)
        else $error("Async port won over a sync port source.");

    // Slots of chosen entries of the peripheral groups.
    chk_ssp1_slot: assert property ((irq_valid && irq_source == IDX_SSP1) |-> irq_address[7:0] == 8'h42)
        else $error("Sync port 1 exception receive slot is wrong.");

    chk_async_slot: assert property ((irq_valid && irq_source == IDX_ASP + N_ASP - 1)
        |-> irq_address[7:0] == 8'h58)
        else $error("Async port timer slot is wrong.");

    chk_host_slot: assert property ((irq_valid && irq_source == IDX_HOST + N_HOST - 1)
        |-> irq_address[7:0] == 8'h70)
        else $error("Host master address slot is wrong.");

    // Reserved and unassigned slots are never presented.
    chk_no_reserved: assert property (irq_valid
        |-> !(irq_address[7:0] inside {8'h0C, 8'h0E, 8'h3C, 8'h3E, 8'h4C, 8'h4E, 8'h5A, 8'h5C, 8'h5E}))
        else $error("A reserved vector slot was presented.");

endmodule

// [hdl/ivp_pkg.sv]
// Constants shared by the interrupt vector and priority arbiter.
// Assumes a 24-bit program address space and two-word vector slots.
package ivp_pkg;

    // Widths of the arbiter's buses.
    localparam int NSRC = 50;
    localparam int IDX_W = 6;
    localparam int LVL_W = 2;
    localparam int ADDR_W = 24;
    localparam int SLOT_W = 8;
    localparam int NLVL = 4;

    // Level codes: 3 is the nonmaskable level, and a maskable source set to 3 is disabled.
    localparam logic [1:0] LVL_NMI = 2'h3;
    localparam logic [1:0] LVL_OFF = 2'h3;

    // Position of each source group in the fixed priority order, index 0 highest.
    localparam int IDX_RESET = 0;
    localparam int IDX_STACK = 1;
    localparam int IDX_ILLEGAL = 2;
    localparam int IDX_DEBUG = 3;
    localparam int IDX_TRAP = 4;
    localparam int IDX_NMI = 5;
    localparam int IDX_HC_NMI = 6;
    localparam int IDX_EXT = 7;
    localparam int IDX_DMA = 11;
    localparam int IDX_HC = 17;
    localparam int IDX_HOST = 18;
    localparam int IDX_SSP0 = 27;
    localparam int IDX_SSP1 = 33;
    localparam int IDX_ASP = 39;
    localparam int IDX_TMR = 44;

    // Group sizes.
    localparam int N_EXT = 4;
    localparam int N_DMA = 6;
    localparam int N_HOST = 9;
    localparam int N_SSP = 6;
    localparam int N_ASP = 5;
    localparam int N_TMR = 6;

    // Vector slot offset for each index of the priority order.
    localparam logic [SLOT_W-1:0] SLOT [NSRC] = '{
        8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h72,
        8'h10, 8'h12, 8'h14, 8'h16,
        8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22,
        8'h72,
        8'h60, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6A, 8'h6C, 8'h6E, 8'h70,
        8'h32, 8'h30, 8'h34, 8'h38, 8'h3A, 8'h36,
        8'h42, 8'h40, 8'h44, 8'h48, 8'h4A, 8'h46,
        8'h52, 8'h50, 8'h54, 8'h56, 8'h58,
        8'h26, 8'h24, 8'h2A, 8'h28, 8'h2E, 8'h2C
    };

    // Reset values of the grant outputs.
    localparam logic [ADDR_W-1:0] RST_ADDR = 24'h00_0000;
    localparam logic [IDX_W-1:0] RST_SRC = 6'h00;
    localparam logic [LVL_W-1:0] RST_LVL = 2'h0;

endpackage

// [hdl/ivp_first_pick.sv]
// Finds the lowest set bit of a request vector.
// Assumes index 0 is the highest priority; purely combinational.
`timescale 1ns/100ps

module ivp_first_pick #(
    parameter int N = 50,
    parameter int W = 6
) (
    // Requests, bit 0 first.
    input wire logic [N-1:0] req,
    // Result.
    output logic any,
    output logic [W-1:0] idx
);

    // Scan downward so the lowest set index is left standing.
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = W'(i);
            end
        end
    end

endmodule

// [testbench/ivp_req_model.sv]
// Request source model: spreads a request vector in priority order onto the arbiter's request ports.
// Assumes the bench changes req and lvl just after a rising mclk edge and holds them as levels.
`timescale 1ns/100ps

module ivp_req_model
    import ivp_pkg::*;
(
    // Requests and levels by priority index.
    input wire logic [ivp_pkg::NSRC-1:0] req,
    input wire logic [ivp_pkg::NSRC-1:0][ivp_pkg::LVL_W-1:0] lvl,
    // Core and external requests.
    output logic [5:0] core_req,
    output logic [ivp_pkg::N_EXT-1:0] ext_req,
    output logic [ivp_pkg::N_EXT-1:0][ivp_pkg::LVL_W-1:0] ext_level,
    // Peripheral requests.
    output logic [ivp_pkg::N_DMA-1:0] dma_req,
    output logic [ivp_pkg::N_DMA-1:0][ivp_pkg::LVL_W-1:0] dma_level,
    output logic host_cmd_req,
    output logic host_cmd_maskable,
    output logic [ivp_pkg::N_HOST-1:0] host_req,
    output logic [ivp_pkg::N_SSP-1:0] ssp0_req,
    output logic [ivp_pkg::N_SSP-1:0] ssp1_req,
    output logic [ivp_pkg::N_ASP-1:0] asp_req,
    output logic [ivp_pkg::N_TMR-1:0] tmr_req,
    // Group levels, taken from the first source of each group.
    output logic [ivp_pkg::LVL_W-1:0] host_level,
    output logic [ivp_pkg::LVL_W-1:0] ssp0_level,
    output logic [ivp_pkg::LVL_W-1:0] ssp1_level,
    output logic [ivp_pkg::LVL_W-1:0] asp_level,
    output logic [ivp_pkg::LVL_W-1:0] tmr_level
);
    import ivp_pkg::*;

    // Core exceptions are fixed at the nonmaskable level; peripherals carry a level each.
    assign core_req = req[5:0];
    assign ext_req = req[IDX_EXT +: N_EXT];
    assign ext_level = lvl[IDX_EXT +: N_EXT];
    assign dma_req = req[IDX_DMA +: N_DMA];
    assign dma_level = lvl[IDX_DMA +: N_DMA];
    // The host command is nonmaskable unless the maskable slot is requested.
    assign host_cmd_req = req[IDX_HC_NMI] | req[IDX_HC];
    assign host_cmd_maskable = req[IDX_HC];
    assign host_req = req[IDX_HOST +: N_HOST];
    assign ssp0_req = req[IDX_SSP0 +: N_SSP];
    assign ssp1_req = req[IDX_SSP1 +: N_SSP];
    assign asp_req = req[IDX_ASP +: N_ASP];
    assign tmr_req = req[IDX_TMR +: N_TMR];
    // Group levels.
    assign host_level = lvl[IDX_HOST];
    assign ssp0_level = lvl[IDX_SSP0];
    assign ssp1_level = lvl[IDX_SSP1];
    assign asp_level = lvl[IDX_ASP];
    assign tmr_level = lvl[IDX_TMR];
endmodule

// [testbench/tb.sv]
// Self-checking bench for the interrupt vector and priority arbiter.
// Assumes one grant word per cycle, one cycle after the requests are applied.
`timescale 1ns/100ps

module tb;
    import ivp_pkg::*;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [NSRC-1:0] req = '0;
    logic [NSRC-1:0][LVL_W-1:0] lvl = '0;
    logic [LVL_W-1:0] core_mask = 2'h0;
    logic [ADDR_W-1:0] base = 24'hAB_CD00;
    logic [5:0] core_req;
    logic [N_EXT-1:0] ext_req;
    logic [N_EXT-1:0][LVL_W-1:0] ext_level;
    logic [N_DMA-1:0] dma_req;
    logic [N_DMA-1:0][LVL_W-1:0] dma_level;
    logic hc_req, hc_m;
    logic [N_HOST-1:0] host_req;
    logic [N_SSP-1:0] s0_req, s1_req;
    logic [N_ASP-1:0] a_req;
    logic [N_TMR-1:0] t_req;
    logic [LVL_W-1:0] h_lv, s0_lv, s1_lv, a_lv, t_lv, irq_level;
    logic irq_valid;
    logic [IDX_W-1:0] irq_source;
    logic [ADDR_W-1:0] irq_address;
    int fails = 0;
    int n_checks = 0;

    // Clock at 200 MHz.
    always #2.5 mclk = ~mclk;

    ivp_req_model pm_u (.req(req), .lvl(lvl), .core_req(core_req), .ext_req(ext_req), .ext_level(ext_level),
        .dma_req(dma_req), .dma_level(dma_level), .host_cmd_req(hc_req), .host_cmd_maskable(hc_m),
        .host_req(host_req), .ssp0_req(s0_req), .ssp1_req(s1_req), .asp_req(a_req), .tmr_req(t_req),
        .host_level(h_lv), .ssp0_level(s0_lv), .ssp1_level(s1_lv), .asp_level(a_lv), .tmr_level(t_lv));

    ivp_arbiter dut_u (.mclk(mclk), .rst(rst), .core_req_reset(core_req[0]), .core_req_stack(core_req[1]),
        .core_req_illegal(core_req[2]), .core_req_debug(core_req[3]), .core_req_trap(core_req[4]),
        .core_req_nmi(core_req[5]), .core_mask(core_mask), .vector_base(base), .ext_request_a(ext_req[0]),
        .ext_request_b(ext_req[1]), .ext_request_c(ext_req[2]), .ext_request_d(ext_req[3]),
        .ext_level(ext_level), .dma_req(dma_req), .dma_level(dma_level), .host_cmd_req(hc_req),
        .host_cmd_maskable(hc_m), .host_req(host_req), .host_level(h_lv), .sync_serial_port0_req(s0_req),
        .sync_serial_port0_level(s0_lv), .sync_serial_port1_req(s1_req), .sync_serial_port1_level(s1_lv),
        .async_serial_port_req(a_req), .async_serial_port_level(a_lv), .timer_req(t_req), .timer_level(t_lv),
        .irq_valid(irq_valid), .irq_level(irq_level), .irq_source(irq_source), .irq_address(irq_address));

    // Compares one value and reports a mismatch.
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Checks that every grant output shows its reset value.
    task automatic chk_reset_vals;
        chk(24'(irq_valid), 24'h00_0000);
        chk(24'(irq_level), 24'(RST_LVL));
        chk(24'(irq_source), 24'(RST_SRC));
        chk(irq_address, RST_ADDR);
    endtask

    // Slot offset of each priority index, worked out from the vector table.
    function automatic logic [7:0] slot_of(int i);
        logic [7:0] ss [6] = '{8'h02, 8'h00, 8'h04, 8'h08, 8'h0A, 8'h06};
        logic [7:0] as [5] = '{8'h52, 8'h50, 8'h54, 8'h56, 8'h58};
        if (i < 6) return 8'(i * 2);
        if (i == 6 || i == 17) return 8'h72;
        if (i < 17) return 8'(16 + (i - 7) * 2);
        if (i < 27) return 8'(96 + (i - 18) * 2);
        if (i < 39) return ((i < 33) ? 8'h30 : 8'h40) + ss[(i - 27) % 6];
        if (i < 44) return as[i - 39];
        return 8'(36 + ((i - 44) / 2) * 4 + ((i % 2 == 0) ? 2 : 0));
    endfunction

    // Applies requests and, one cycle later, checks the grant against the expected winner.
    task automatic step(input logic [NSRC-1:0] r, input logic [1:0] m);
        int best;
        int bl;
        int e;
        best = -1;
        bl = 0;
        @(posedge mclk);
        req <= r;
        core_mask <= m;
        for (int i = 0; i < NSRC; i++) begin
            // Grouped sources share the level of their group's first entry.
            e = (i <= 6) ? 3 : int'(lvl[i]);
            if (i >= 17) e = int'(lvl[(i < 27) ? 18 : (i < 33) ? 27 : (i < 39) ? 33 : (i < 44) ? 39 : 44]);
            if (r[i] && ((i <= 6) || (e != 3 && e >= m)) && (best < 0 || e > bl)) begin
                best = i;
                bl = e;
            end
        end
        @(posedge mclk);
        #1;
        chk(24'(irq_valid), 24'(best >= 0));
        if (best >= 0) begin
            chk(24'(irq_level), 24'(bl));
            chk(24'(irq_source), 24'(best));
            chk(irq_address, {base[23:8], slot_of(best)});
        end
    endtask

    // Nonmaskable sources granted in fixed order even with all maskable levels masked.
    task automatic t_nmi;
        logic [NSRC-1:0] r;
        r = '0;
        r[6:0] = 7'h7F;
        for (int k = 0; k < 7; k++) begin
            step(r, 2'h3);
            r[k] = 1'b0;
        end
    endtask

    // Every maskable source at one level, dropped winner by winner.
    task automatic t_order;
        logic [NSRC-1:0] r;
        r = '1;
        r[6:0] = 7'h00;
        @(posedge mclk);
        for (int i = 0; i < NSRC; i++) lvl[i] <= 2'h1;
        for (int k = 7; k < NSRC; k++) begin
            step(r, 2'h0);
            r[k] = 1'b0;
        end
        step(r, 2'h0);
    endtask

    // Levels beat order; mask levels and the disabled code hold sources off.
    task automatic t_levels;
        logic [NSRC-1:0] r;
        r = '0;
        r[7] = 1'b1;
        r[11] = 1'b1;
        r[49] = 1'b1;
        @(posedge mclk);
        lvl[7] <= 2'h0;
        lvl[11] <= 2'h1;
        for (int i = 44; i < 50; i++) lvl[i] <= 2'h2;
        for (int m = 0; m < 4; m++) step(r, 2'(m));
        @(posedge mclk);
        for (int i = 44; i < 50; i++) lvl[i] <= 2'h3;
        step(r, 2'h1);
    endtask

    // Host command: nonmaskable by default, maskable form obeys the mask.
    task automatic t_hc;
        @(posedge mclk);
        base <= 24'h12_34FF;
        lvl[18] <= 2'h2;
        step(NSRC'(1) << 6, 2'h3);
        step(NSRC'(1) << 17, 2'h3);
        step(NSRC'(1) << 17, 2'h2);
        step((NSRC'(1) << 6) | (NSRC'(1) << 7), 2'h0);
    endtask

    // Mid-run reset clears a standing grant; the held request is granted again afterwards.
    task automatic t_reset;
        step(NSRC'(1) << 5, 2'h0);
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk_reset_vals();
        step(NSRC'(1) << 5, 2'h0);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence after six reset cycles.
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk_reset_vals();
        t_nmi();
        t_order();
        t_levels();
        t_hc();
        t_reset();
        report_and_stop();
    end

    // Watchdog well past the roughly 140 cycles the tests need.
    initial begin
        #20000;
        fails++;
        report_and_stop();
    end
endmodule
